// >>> verilog/hms_pkg.sv
// package: constants and types of the mode and setpoint selector
`default_nettype none
package hms_pkg;
   // ----------------------------------------------------------------
   // operating modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      HMS_COMFORT = 2'h0,
      HMS_STANDBY = 2'h1,
      HMS_NIGHT = 2'h2,
      HMS_FROST = 2'h3
   } hms_mode_t;

   // ----------------------------------------------------------------
   // widths and timing
   // ----------------------------------------------------------------
   localparam int HMS_AW = 8;
   localparam int HMS_DW = 16;
   localparam int HMS_NSRC = 4;
   localparam longint HMS_CLK_PERIOD_NS = 20;
   localparam longint HMS_SECOND_NS = 1000000000;
   localparam int HMS_CYC_PER_SEC = int'(HMS_SECOND_NS / HMS_CLK_PERIOD_NS);

   // ----------------------------------------------------------------
   // mode sources, index order is tie-break order
   // ----------------------------------------------------------------
   localparam int HMS_SRC_PRESET = 0;
   localparam int HMS_SRC_PAGE = 1;
   localparam int HMS_SRC_TIMER = 2;
   localparam int HMS_SRC_SCENE = 3;

   // ----------------------------------------------------------------
   // synchronised level inputs
   // ----------------------------------------------------------------
   localparam int HMS_NLVL = 6;
   localparam int HMS_LVL_PRES = 0;
   localparam int HMS_LVL_WIN = 1;
   localparam int HMS_LVL_ONIGHT = 2;
   localparam int HMS_LVL_OCOMF = 3;
   localparam int HMS_LVL_OFROST = 4;
   localparam int HMS_LVL_POFS = 5;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [HMS_AW-1:0] HMS_OFS_CTRL = 8'h00;
   localparam logic [HMS_AW-1:0] HMS_OFS_BASE = 8'h04;
   localparam logic [HMS_AW-1:0] HMS_OFS_USER_OFS = 8'h08;
   localparam logic [HMS_AW-1:0] HMS_OFS_MAX_OFS = 8'h0c;
   localparam logic [HMS_AW-1:0] HMS_OFS_STBY_RED = 8'h10;
   localparam logic [HMS_AW-1:0] HMS_OFS_DEAD = 8'h14;
   localparam logic [HMS_AW-1:0] HMS_OFS_STBY_INC = 8'h18;
   localparam logic [HMS_AW-1:0] HMS_OFS_NIGHT_INC = 8'h1c;
   localparam logic [HMS_AW-1:0] HMS_OFS_FROST_SP = 8'h20;
   localparam logic [HMS_AW-1:0] HMS_OFS_HEAT_SP = 8'h24;
   localparam logic [HMS_AW-1:0] HMS_OFS_EXT_TIME = 8'h28;
   localparam logic [HMS_AW-1:0] HMS_OFS_STATUS = 8'h2c;
   localparam logic [HMS_AW-1:0] HMS_OFS_SETPOINT = 8'h30;

   // ----------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------
   localparam int HMS_CTRL_NEW = 0;
   localparam int HMS_CTRL_PRES_OPT = 1;
   localparam int HMS_CTRL_COOL = 2;
   localparam int HMS_CTRL_W = 3;

   // ----------------------------------------------------------------
   // reset values, temperatures in 0.01 K
   // ----------------------------------------------------------------
   localparam logic [HMS_CTRL_W-1:0] HMS_RST_CTRL = 3'h1;
   localparam logic [HMS_DW-1:0] HMS_RST_BASE = 16'h0834;
   localparam logic [HMS_DW-1:0] HMS_RST_USER_OFS = 16'h0000;
   localparam logic [HMS_DW-1:0] HMS_RST_MAX_OFS = 16'h00c8;
   localparam logic [HMS_DW-1:0] HMS_RST_STBY_RED = 16'h00c8;
   localparam logic [HMS_DW-1:0] HMS_RST_DEAD = 16'h00c8;
   localparam logic [HMS_DW-1:0] HMS_RST_STBY_INC = 16'h00c8;
   localparam logic [HMS_DW-1:0] HMS_RST_NIGHT_INC = 16'h0190;
   localparam logic [HMS_DW-1:0] HMS_RST_FROST_SP = 16'h02bc;
   localparam logic [HMS_DW-1:0] HMS_RST_HEAT_SP = 16'h0dac;
   localparam logic [HMS_DW-1:0] HMS_RST_EXT_TIME = 16'h0e10;
endpackage
`default_nettype wire

// >>> verilog/hms_calc_if.sv
// interface: selector to setpoint calculator
`timescale 1ns/1ns
`default_nettype none
interface hms_calc_if;
   import hms_pkg::*;
   hms_mode_t mode;
   logic cooling;
   logic signed [HMS_DW-1:0] base;
   logic signed [HMS_DW-1:0] user_ofs;
   logic signed [HMS_DW-1:0] stby_red;
   logic signed [HMS_DW-1:0] dead;
   logic signed [HMS_DW-1:0] stby_inc;
   logic signed [HMS_DW-1:0] night_inc;
   logic signed [HMS_DW-1:0] frost_sp;
   logic signed [HMS_DW-1:0] heat_sp;
   logic signed [HMS_DW-1:0] setpoint;

   modport sel
   (
      output mode, cooling, base, user_ofs, stby_red, dead, stby_inc,
      output night_inc, frost_sp, heat_sp,
      input setpoint
   );
   modport calc
   (
      input mode, cooling, base, user_ofs, stby_red, dead, stby_inc,
      input night_inc, frost_sp, heat_sp,
      output setpoint
   );
endinterface
`default_nettype wire

// >>> verilog/hms_setpoint_calc.sv
// setpoint calculator: current setpoint from mode and configuration
`timescale 1ns/1ns
`default_nettype none
module hms_setpoint_calc
   import hms_pkg::*;
(
   hms_calc_if.calc c
);
   logic signed [HMS_DW-1:0] heat_comfort;
   logic signed [HMS_DW-1:0] cool_comfort;

   // ----------------------------------------------------------------
   // setpoint per mode
   // ----------------------------------------------------------------
   // offset always taken against the base value
   assign heat_comfort = c.base + c.user_ofs;
   assign cool_comfort = heat_comfort + c.dead;

   always_comb
   begin
      c.setpoint = heat_comfort;
      if (!c.cooling)
      begin
         case (c.mode)
            HMS_COMFORT: c.setpoint = heat_comfort;
            HMS_STANDBY: c.setpoint = heat_comfort - c.stby_red;
            HMS_NIGHT: c.setpoint = heat_comfort - c.stby_red;
            HMS_FROST: c.setpoint = c.frost_sp;
            default: c.setpoint = heat_comfort;
         endcase
      end
      else
      begin
         case (c.mode)
            HMS_COMFORT: c.setpoint = cool_comfort;
            HMS_STANDBY: c.setpoint = cool_comfort + c.stby_inc;
            HMS_NIGHT: c.setpoint = cool_comfort + c.night_inc;
            HMS_FROST: c.setpoint = c.heat_sp;
            default: c.setpoint = cool_comfort;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> verilog/hms_mode_setpoint_select.sv
// top: operating mode arbitration, presence handling, register port
`timescale 1ns/1ns
`default_nettype none
module hms_mode_setpoint_select
   import hms_pkg::*;
#(
   parameter int unsigned CYC_PER_SEC = HMS_CYC_PER_SEC
)
(
   input wire logic I_SYS_CLK,
   input wire logic I_RSTN,
   input wire logic [HMS_AW-1:0] I_ADDR,
   input wire logic [HMS_DW-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [HMS_DW-1:0] O_RDATA,
   input wire logic I_PRESET_VLD,
   input wire logic [1:0] I_PRESET_MODE,
   input wire logic I_PAGE_VLD,
   input wire logic [1:0] I_PAGE_MODE,
   input wire logic I_TIMER_VLD,
   input wire logic [1:0] I_TIMER_MODE,
   input wire logic I_SCENE_VLD,
   input wire logic [1:0] I_SCENE_MODE,
   input wire logic I_PRESENCE,
   input wire logic I_WINDOW,
   input wire logic I_OLD_NIGHT,
   input wire logic I_OLD_COMFORT,
   input wire logic I_OLD_FROST,
   input wire logic I_PAGE_OFS_VLD,
   input wire logic [HMS_DW-1:0] I_PAGE_OFS,
   output logic [1:0] O_CUR_MODE,
   output logic [HMS_DW-1:0] O_SETPOINT,
   output logic O_PRESENCE
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [HMS_NSRC-1:0] vld_s1;
      logic [HMS_NSRC-1:0] vld_s2;
      logic [HMS_NSRC-1:0] vld_d;
      logic [HMS_NSRC-1:0][1:0] mode_s1;
      logic [HMS_NSRC-1:0][1:0] mode_s2;
      logic [HMS_NLVL-1:0] lvl_s1;
      logic [HMS_NLVL-1:0] lvl_s2;
      logic [HMS_NLVL-1:0] lvl_d;
      logic [HMS_DW-1:0] pofs_s1;
      logic [HMS_DW-1:0] pofs_s2;
      logic [HMS_CTRL_W-1:0] ctrl;
      logic [HMS_DW-1:0] base;
      logic [HMS_DW-1:0] user_ofs;
      logic [HMS_DW-1:0] max_ofs;
      logic [HMS_DW-1:0] stby_red;
      logic [HMS_DW-1:0] dead;
      logic [HMS_DW-1:0] stby_inc;
      logic [HMS_DW-1:0] night_inc;
      logic [HMS_DW-1:0] frost_sp;
      logic [HMS_DW-1:0] heat_sp;
      logic [HMS_DW-1:0] ext_time;
      hms_mode_t sel_mode;
      hms_mode_t pre_pres_mode;
      logic pres;
      logic ext_run;
      logic [31:0] prescale;
      logic [HMS_DW-1:0] ext_cnt;
      hms_mode_t cur_mode;
      logic [HMS_DW-1:0] setpoint;
      logic [HMS_DW-1:0] rdata;
   } hms_state_t;

   hms_state_t st_reg;
   hms_state_t st_next;
   hms_calc_if calc_bus();
   hms_mode_t new_mode;
   hms_mode_t old_mode;

   // ----------------------------------------------------------------
   // offset limiter
   // ----------------------------------------------------------------
   function automatic logic [HMS_DW-1:0] clamp_ofs
   (
      input logic [HMS_DW-1:0] ofs,
      input logic [HMS_DW-1:0] lim
   );
      logic signed [HMS_DW-1:0] s;
      logic signed [HMS_DW-1:0] l;
      s = ofs;
      l = lim;
      if (s > l)
         return l;
      else if (s < -l)
         return -l;
      else
         return s;
   endfunction

   // ----------------------------------------------------------------
   // setpoint calculator
   // ----------------------------------------------------------------
   assign calc_bus.mode = st_reg.cur_mode;
   assign calc_bus.cooling = st_reg.ctrl[HMS_CTRL_COOL];
   assign calc_bus.base = st_reg.base;
   assign calc_bus.user_ofs = st_reg.user_ofs;
   assign calc_bus.stby_red = st_reg.stby_red;
   assign calc_bus.dead = st_reg.dead;
   assign calc_bus.stby_inc = st_reg.stby_inc;
   assign calc_bus.night_inc = st_reg.night_inc;
   assign calc_bus.frost_sp = st_reg.frost_sp;
   assign calc_bus.heat_sp = st_reg.heat_sp;

   hms_setpoint_calc u_calc
   (
      .c(calc_bus.calc)
   );

   // ----------------------------------------------------------------
   // scheme tables
   // ----------------------------------------------------------------
   always_comb
   begin
      if (st_reg.lvl_s2[HMS_LVL_WIN])
         new_mode = HMS_FROST;
      else if (st_reg.pres)
         new_mode = HMS_COMFORT;
      else
         new_mode = st_reg.sel_mode;
      if (st_reg.lvl_s2[HMS_LVL_OFROST])
         old_mode = HMS_FROST;
      else if (st_reg.lvl_s2[HMS_LVL_OCOMF])
         old_mode = HMS_COMFORT;
      else if (st_reg.lvl_s2[HMS_LVL_ONIGHT])
         old_mode = HMS_NIGHT;
      else
         old_mode = HMS_STANDBY;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic opt;
      logic pres_rise;
      logic pres_fall;
      logic [HMS_NSRC-1:0] rx;
      hms_mode_t m;
      opt = 1'b0;
      pres_rise = 1'b0;
      pres_fall = 1'b0;
      rx = '0;
      m = HMS_COMFORT;
      st_next = st_reg;

      // input synchronisers
      st_next.vld_s1 = {I_SCENE_VLD, I_TIMER_VLD, I_PAGE_VLD, I_PRESET_VLD};
      st_next.vld_s2 = st_reg.vld_s1;
      st_next.vld_d = st_reg.vld_s2;
      st_next.mode_s1 = {I_SCENE_MODE, I_TIMER_MODE, I_PAGE_MODE,
                         I_PRESET_MODE};
      st_next.mode_s2 = st_reg.mode_s1;
      st_next.lvl_s1 = {I_PAGE_OFS_VLD, I_OLD_FROST, I_OLD_COMFORT,
                        I_OLD_NIGHT, I_WINDOW, I_PRESENCE};
      st_next.lvl_s2 = st_reg.lvl_s1;
      st_next.lvl_d = st_reg.lvl_s2;
      st_next.pofs_s1 = I_PAGE_OFS;
      st_next.pofs_s2 = st_reg.pofs_s1;

      opt = st_reg.ctrl[HMS_CTRL_PRES_OPT];
      rx = st_reg.vld_s2 & ~st_reg.vld_d;
      pres_rise = st_reg.lvl_s2[HMS_LVL_PRES] & ~st_reg.lvl_d[HMS_LVL_PRES];
      pres_fall = ~st_reg.lvl_s2[HMS_LVL_PRES] & st_reg.lvl_d[HMS_LVL_PRES];

      // presence state
      if (!opt)
      begin
         st_next.pres = st_reg.lvl_s2[HMS_LVL_PRES];
         st_next.ext_run = 1'b0;
      end
      else if (pres_rise)
      begin
         st_next.pres = 1'b1;
         st_next.pre_pres_mode = st_reg.sel_mode;
         st_next.prescale = '0;
         st_next.ext_cnt = st_reg.ext_time;
         st_next.ext_run = (st_reg.sel_mode == HMS_NIGHT) ||
                           (st_reg.sel_mode == HMS_FROST);
      end
      else if (pres_fall)
      begin
         st_next.pres = 1'b0;
         st_next.ext_run = 1'b0;
      end
      else if (st_reg.ext_run)
      begin
         if (st_reg.prescale == 32'(CYC_PER_SEC - 1))
         begin
            st_next.prescale = '0;
            if (st_reg.ext_cnt == '0)
            begin
               st_next.pres = 1'b0;
               st_next.ext_run = 1'b0;
            end
            else
               st_next.ext_cnt = st_reg.ext_cnt - 16'h0001;
         end
         else
            st_next.prescale = st_reg.prescale + 32'h0000_0001;
      end

      // mode sources, lowest index wins a tie
      for (int i = HMS_NSRC - 1; i >= 0; i--)
      begin
         if (rx[i])
         begin
            m = hms_mode_t'(st_reg.mode_s2[i]);
            if (i == HMS_SRC_PRESET && opt && st_reg.pres)
            begin
               if (m != st_reg.pre_pres_mode)
               begin
                  st_next.sel_mode = m;
                  st_next.pres = 1'b0;
                  st_next.ext_run = 1'b0;
               end
            end
            else
               st_next.sel_mode = m;
         end
      end

      // local page offset entry
      if (st_reg.lvl_s2[HMS_LVL_POFS] && !st_reg.lvl_d[HMS_LVL_POFS])
         st_next.user_ofs = clamp_ofs(st_reg.pofs_s2, st_reg.max_ofs);

      // register writes
      if (I_WR)
      begin
         case (I_ADDR)
            HMS_OFS_CTRL: st_next.ctrl = I_WDATA[HMS_CTRL_W-1:0];
            HMS_OFS_BASE: st_next.base = I_WDATA;
            HMS_OFS_USER_OFS:
               st_next.user_ofs = clamp_ofs(I_WDATA, st_reg.max_ofs);
            HMS_OFS_MAX_OFS: st_next.max_ofs = I_WDATA;
            HMS_OFS_STBY_RED: st_next.stby_red = I_WDATA;
            HMS_OFS_DEAD: st_next.dead = I_WDATA;
            HMS_OFS_STBY_INC: st_next.stby_inc = I_WDATA;
            HMS_OFS_NIGHT_INC: st_next.night_inc = I_WDATA;
            HMS_OFS_FROST_SP: st_next.frost_sp = I_WDATA;
            HMS_OFS_HEAT_SP: st_next.heat_sp = I_WDATA;
            HMS_OFS_EXT_TIME: st_next.ext_time = I_WDATA;
            default: st_next.ctrl = st_reg.ctrl;
         endcase
      end

      // current mode and setpoint, refreshed every cycle
      if (st_reg.ctrl[HMS_CTRL_NEW])
         st_next.cur_mode = new_mode;
      else
         st_next.cur_mode = old_mode;
      st_next.setpoint = calc_bus.setpoint;

      // register reads, data valid one cycle later only
      st_next.rdata = '0;
      if (I_RD)
      begin
         case (I_ADDR)
            HMS_OFS_CTRL: st_next.rdata = {13'h0000, st_reg.ctrl};
            HMS_OFS_BASE: st_next.rdata = st_reg.base;
            HMS_OFS_USER_OFS: st_next.rdata = st_reg.user_ofs;
            HMS_OFS_MAX_OFS: st_next.rdata = st_reg.max_ofs;
            HMS_OFS_STBY_RED: st_next.rdata = st_reg.stby_red;
            HMS_OFS_DEAD: st_next.rdata = st_reg.dead;
            HMS_OFS_STBY_INC: st_next.rdata = st_reg.stby_inc;
            HMS_OFS_NIGHT_INC: st_next.rdata = st_reg.night_inc;
            HMS_OFS_FROST_SP: st_next.rdata = st_reg.frost_sp;
            HMS_OFS_HEAT_SP: st_next.rdata = st_reg.heat_sp;
            HMS_OFS_EXT_TIME: st_next.rdata = st_reg.ext_time;
            HMS_OFS_STATUS:
               st_next.rdata = {8'h00, st_reg.pre_pres_mode,
                                st_reg.sel_mode, st_reg.ext_run,
                                st_reg.pres, st_reg.cur_mode};
            HMS_OFS_SETPOINT: st_next.rdata = st_reg.setpoint;
            default: st_next.rdata = '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         st_reg <= '0;
         st_reg.ctrl <= HMS_RST_CTRL;
         st_reg.base <= HMS_RST_BASE;
         st_reg.user_ofs <= HMS_RST_USER_OFS;
         st_reg.max_ofs <= HMS_RST_MAX_OFS;
         st_reg.stby_red <= HMS_RST_STBY_RED;
         st_reg.dead <= HMS_RST_DEAD;
         st_reg.stby_inc <= HMS_RST_STBY_INC;
         st_reg.night_inc <= HMS_RST_NIGHT_INC;
         st_reg.frost_sp <= HMS_RST_FROST_SP;
         st_reg.heat_sp <= HMS_RST_HEAT_SP;
         st_reg.ext_time <= HMS_RST_EXT_TIME;
         st_reg.setpoint <= HMS_RST_BASE;
      end
      else
         st_reg <= st_next;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign O_RDATA = st_reg.rdata;
   assign O_CUR_MODE = st_reg.cur_mode;
   assign O_SETPOINT = st_reg.setpoint;
   assign O_PRESENCE = st_reg.pres;

endmodule
`default_nettype wire

// >>> verification/hms_properties.sv
// checker: port-level properties of the mode and setpoint selector
`timescale 1ns/1ns
`default_nettype none
module hms_properties
   import hms_pkg::*;
#(
   parameter int unsigned CYC_PER_SEC = HMS_CYC_PER_SEC
)
(
   input wire logic I_SYS_CLK,
   input wire logic I_RSTN,
   input wire logic [HMS_AW-1:0] I_ADDR,
   input wire logic [HMS_DW-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [HMS_DW-1:0] O_RDATA,
   input wire logic I_PRESENCE,
   input wire logic I_WINDOW,
   input wire logic I_OLD_NIGHT,
   input wire logic I_OLD_COMFORT,
   input wire logic I_OLD_FROST,
   input wire logic [1:0] O_CUR_MODE,
   input wire logic [HMS_DW-1:0] O_SETPOINT,
   input wire logic O_PRESENCE
);
   // ------------------------------
   // shadow of control and limits
   // ------------------------------
   logic [HMS_CTRL_W-1:0] ctrl_reg;
   logic [HMS_DW-1:0] frost_reg;
   logic [HMS_DW-1:0] heat_reg;
   wire logic nw = ctrl_reg[HMS_CTRL_NEW];
   wire logic opt = ctrl_reg[HMS_CTRL_PRES_OPT];
   wire logic cool = ctrl_reg[HMS_CTRL_COOL];
   always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         ctrl_reg <= HMS_RST_CTRL;
         frost_reg <= HMS_RST_FROST_SP;
         heat_reg <= HMS_RST_HEAT_SP;
      end
      else if (I_WR)
      begin
         if (I_ADDR == HMS_OFS_CTRL) ctrl_reg <= I_WDATA[HMS_CTRL_W-1:0];
         if (I_ADDR == HMS_OFS_FROST_SP) frost_reg <= I_WDATA;
         if (I_ADDR == HMS_OFS_HEAT_SP) heat_reg <= I_WDATA;
      end
   end
   // ------------------------------
   // properties
   // ------------------------------
   default clocking dc @(posedge I_SYS_CLK);
   endclocking
   default disable iff (!I_RSTN);
   win_frost_a:
      assert property ((nw && I_WINDOW)[*5] |-> O_CUR_MODE == 2'h3)
      else $error("open window without frost mode");
   pres_comfort_a:
      assert property ((nw && !opt && I_PRESENCE && !I_WINDOW)[*6]
         |-> O_CUR_MODE == 2'h0) else $error("presence without comfort");
   pres_follow_a:
      assert property ((nw && !opt && I_PRESENCE)[*5] |-> O_PRESENCE)
      else $error("presence state not following input");
   old_frost_a:
      assert property ((!nw && I_OLD_FROST)[*5] |-> O_CUR_MODE == 2'h3)
      else $error("old frost input without frost mode");
   old_comfort_a:
      assert property ((!nw && !I_OLD_FROST && I_OLD_COMFORT)[*5]
         |-> O_CUR_MODE == 2'h0) else $error("old comfort ignored");
   old_night_a:
      assert property ((!nw && !I_OLD_FROST && !I_OLD_COMFORT
         && I_OLD_NIGHT)[*5] |-> O_CUR_MODE == 2'h2)
      else $error("old night bit ignored");
   heat_frost_a:
      assert property ((O_CUR_MODE == 2'h3 && !cool && !I_WR)[*3]
         |-> O_SETPOINT == frost_reg) else $error("frost setpoint wrong");
   cool_heat_a:
      assert property ((O_CUR_MODE == 2'h3 && cool && !I_WR)[*3]
         |-> O_SETPOINT == heat_reg) else $error("heat setpoint wrong");
   frost_read_a:
      assert property (I_RD && I_ADDR == HMS_OFS_FROST_SP
         |=> O_RDATA == frost_reg) else $error("frost setpoint readback");
   cover property (O_CUR_MODE == 2'h3 && cool);
   cover property (!nw && O_CUR_MODE == 2'h2);
   cover property (opt && $fell(O_PRESENCE));
endmodule
bind hms_mode_setpoint_select hms_properties #(.CYC_PER_SEC(CYC_PER_SEC))
   hms_properties_i (.I_SYS_CLK, .I_RSTN, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
   .O_RDATA, .I_PRESENCE, .I_WINDOW, .I_OLD_NIGHT, .I_OLD_COMFORT,
   .I_OLD_FROST, .O_CUR_MODE, .O_SETPOINT, .O_PRESENCE);
`default_nettype wire

// >>> verification/hms_bus_model.sv
// model: mode command senders, presence detector and window contacts
`timescale 1ns/1ns
`default_nettype none
module hms_bus_model
(
   input wire logic i_clk,
   output logic [3:0] o_vld,
   output logic [3:0][1:0] o_mode,
   output logic [4:0] o_lvl
);
   initial
   begin
      o_vld = 4'h0;
      o_mode = 8'h00;
      o_lvl = 5'h00;
   end
   // ------------------------------
   // data settles, strobe rises, data held past it
   // ------------------------------
   task automatic send(input int s, input logic [1:0] m, input int slow);
      @(posedge i_clk);
      o_mode[s] <= m;
      repeat (2 + slow) @(posedge i_clk);
      o_vld[s] <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_vld[s] <= 1'b0;
      repeat (3) @(posedge i_clk);
   endtask
   task automatic lvl(input int k, input logic v);
      @(posedge i_clk);
      o_lvl[k] <= v;
   endtask
endmodule
`default_nettype wire

// >>> verification/test_hvac_mode_setpoint_select.sv
// testbench: mode arbitration, presence, schemes and setpoint forming
`timescale 1ns/1ns
`default_nettype none
module test_hvac_mode_setpoint_select
   import hms_pkg::*;
;
   typedef struct {logic [15:0] e; logic [15:0] m;} hms_note_t;
   localparam logic [15:0] RSTV [11] = '{{13'h0, HMS_RST_CTRL},
      HMS_RST_BASE, HMS_RST_USER_OFS, HMS_RST_MAX_OFS, HMS_RST_STBY_RED,
      HMS_RST_DEAD, HMS_RST_STBY_INC, HMS_RST_NIGHT_INC, HMS_RST_FROST_SP,
      HMS_RST_HEAT_SP, HMS_RST_EXT_TIME};
   localparam int OLDK [6] = '{2, 3, 4, 4, 3, 2};
   localparam logic [1:0] OLDM [6] = '{2'h2, 2'h0, 2'h3, 2'h0, 2'h2, 2'h1};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wstb = 1'b0;
   logic rstb = 1'b0;
   logic rd_pend = 1'b0;
   logic pvld = 1'b0;
   logic [15:0] pofs = 16'h0000;
   logic [3:0] vld;
   logic [3:0][1:0] mode;
   logic [4:0] lvl;
   logic [15:0] rdata;
   logic [15:0] sp;
   logic [1:0] cmode;
   logic pres;
   logic [15:0] base = HMS_RST_BASE;
   logic [15:0] ofs = 16'h0000;
   logic [31:0] rnd = 32'hc44ce502;
   logic [1:0] m;
   int failures = 0;
   int checked = 0;
   int cyc = 0;
   hms_note_t n;
   hms_note_t sb [$];
   hms_mode_setpoint_select #(.CYC_PER_SEC(4)) hms_mode_setpoint_select_i
   (
      .I_SYS_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wstb), .I_RD(rstb), .O_RDATA(rdata),
      .I_PRESET_VLD(vld[0]), .I_PRESET_MODE(mode[0]),
      .I_PAGE_VLD(vld[1]), .I_PAGE_MODE(mode[1]),
      .I_TIMER_VLD(vld[2]), .I_TIMER_MODE(mode[2]),
      .I_SCENE_VLD(vld[3]), .I_SCENE_MODE(mode[3]),
      .I_PRESENCE(lvl[0]), .I_WINDOW(lvl[1]), .I_OLD_NIGHT(lvl[2]),
      .I_OLD_COMFORT(lvl[3]), .I_OLD_FROST(lvl[4]),
      .I_PAGE_OFS_VLD(pvld), .I_PAGE_OFS(pofs),
      .O_CUR_MODE(cmode), .O_SETPOINT(sp), .O_PRESENCE(pres)
   );
   hms_bus_model hms_bus_model_i
      (.i_clk(clk), .o_vld(vld), .o_mode(mode), .o_lvl(lvl));
   initial
      forever #10 clk = ~clk;
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic chk(input string nm, input logic [15:0] s,
      input logic [15:0] e);
      checked++;
      if (s !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      wstb <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wstb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e,
      input logic [15:0] mk);
      @(posedge clk);
      rstb <= 1'b1;
      addr <= a;
      sb.push_back('{e, mk});
      @(posedge clk);
      rstb <= 1'b0;
   endtask
   task automatic page_ofs(input logic [15:0] v);
      @(posedge clk);
      pofs <= v;
      repeat (2) @(posedge clk);
      pvld <= 1'b1;
      repeat (4) @(posedge clk);
      pvld <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   function automatic logic [15:0] exp_sp(input logic [1:0] em,
      input logic cool);
      logic [15:0] c;
      c = base + ofs + (cool ? HMS_RST_DEAD : 16'h0000);
      case (em)
         2'h0: return c;
         2'h1: return cool ? c + HMS_RST_STBY_INC : c - HMS_RST_STBY_RED;
         2'h2: return cool ? c + HMS_RST_NIGHT_INC : c - HMS_RST_STBY_RED;
         default: return cool ? HMS_RST_HEAT_SP : HMS_RST_FROST_SP;
      endcase
   endfunction
   task automatic expect_mode(input logic [1:0] em, input logic cool);
      rd(HMS_OFS_STATUS, {14'h0, em}, 16'h0003);
      rd(HMS_OFS_SETPOINT, exp_sp(em, cool), 16'hffff);
      #1;
      chk("current mode", {14'h0, cmode}, {14'h0, em});
      chk("setpoint", sp, exp_sp(em, cool));
   endtask
   task automatic done(input string t);
      $display("test %s finished", t);
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // ------------------------------
   // read monitor and run limit
   // ------------------------------
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (rd_pend && sb.size() > 0)
      begin
         n = sb.pop_front();
         chk("read data", rdata & n.m, n.e & n.m);
      end
      rd_pend <= rstb;
      if (cyc == 20000)
      begin
         failures++;
         report_and_stop();
      end
   end
   // ------------------------------
   // scenarios
   // ------------------------------
   initial
   begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 11; i++)
         rd(8'(4 * i), RSTV[i], 16'hffff);
      wr(8'h40, 16'hffff);
      wr(HMS_OFS_SETPOINT, 16'h1234);
      rd(8'h40, 16'h0000, 16'hffff);
      expect_mode(2'h0, 1'b0);
      done("reset");
      for (int c = 0; c < 2; c++)
      begin
         wr(HMS_OFS_CTRL, {13'h0, c[0], 2'h1});
         for (int k = 0; k < 16; k++)
         begin
            rnd = lfsr(rnd);
            m = k[1:0] + rnd[1:0];
            hms_bus_model_i.send(k / 4, m, int'(rnd[3:2]));
            expect_mode(m, c[0]);
         end
      end
      done("sources");
      wr(HMS_OFS_CTRL, 16'h0001);
      hms_bus_model_i.send(0, 2'h0, 0);
      wr(HMS_OFS_USER_OFS, 16'h0064);
      ofs = 16'h0064;
      expect_mode(2'h0, 1'b0);
      wr(HMS_OFS_USER_OFS, 16'h1000);
      ofs = HMS_RST_MAX_OFS;
      expect_mode(2'h0, 1'b0);
      wr(HMS_OFS_BASE, 16'h07d0);
      base = 16'h07d0;
      expect_mode(2'h0, 1'b0);
      page_ofs(16'hf000);
      ofs = -HMS_RST_MAX_OFS;
      expect_mode(2'h0, 1'b0);
      done("offset");
      hms_bus_model_i.lvl(1, 1'b1);
      repeat (8) @(posedge clk);
      expect_mode(2'h3, 1'b0);
      hms_bus_model_i.send(2, 2'h1, 0);
      expect_mode(2'h3, 1'b0);
      hms_bus_model_i.lvl(1, 1'b0);
      repeat (8) @(posedge clk);
      expect_mode(2'h1, 1'b0);
      hms_bus_model_i.lvl(0, 1'b1);
      repeat (8) @(posedge clk);
      chk("presence", {15'h0, pres}, 16'h0001);
      expect_mode(2'h0, 1'b0);
      hms_bus_model_i.lvl(0, 1'b0);
      repeat (8) @(posedge clk);
      expect_mode(2'h1, 1'b0);
      done("window and presence");
      wr(HMS_OFS_CTRL, 16'h0000);
      for (int i = 0; i < 6; i++)
      begin
         hms_bus_model_i.lvl(OLDK[i], i < 3);
         repeat (8) @(posedge clk);
         expect_mode(OLDM[i], 1'b0);
      end
      done("old scheme");
      wr(HMS_OFS_EXT_TIME, 16'h0004);
      wr(HMS_OFS_CTRL, 16'h0003);
      expect_mode(2'h1, 1'b0);
      hms_bus_model_i.lvl(0, 1'b1);
      repeat (48) @(posedge clk);
      expect_mode(2'h0, 1'b0);
      hms_bus_model_i.send(0, 2'h1, 0);
      chk("presence", {15'h0, pres}, 16'h0001);
      expect_mode(2'h0, 1'b0);
      hms_bus_model_i.send(0, 2'h2, 1);
      chk("presence", {15'h0, pres}, 16'h0000);
      expect_mode(2'h2, 1'b0);
      hms_bus_model_i.lvl(0, 1'b0);
      repeat (8) @(posedge clk);
      hms_bus_model_i.lvl(0, 1'b1);
      repeat (8) @(posedge clk);
      expect_mode(2'h0, 1'b0);
      repeat (40) @(posedge clk);
      chk("presence", {15'h0, pres}, 16'h0000);
      expect_mode(2'h2, 1'b0);
      done("presence option");
      repeat (4) @(posedge clk);
      report_and_stop();
   end
endmodule
`default_nettype wire
